/* File: rtl/gbd_decoder.sv */
// Bus command decoder: acceptor and source handshake, command decode,
// address matching, serial poll, response and display-text limits.
// Assumes the bus pins are synchronous to mclk, asserted = 1.
//
// How it works
// R01 - GTL, SDC, GET act only when listening
// R02 - LLO and DCL act without addressing
// R03 - SPE enters, SPD leaves serial poll
// R04 - Own listen address makes us listener
// R05 - Own talk address talks, other stops
// R06 - Unlisten and untalk beat address 31
// R07 - ATN bytes are commands, else data
// R08 - Controller sends UNL, address, command under ATN
// R09 - Controller addresses, releases ATN, sends text
// R10 - Primary addresses above 30 are refused
// R11 - New address adopted, bus state reset
// R12 - Responses are stored when parsed
// R13 - Only one response unit held at once
// R14 - Display text limited to 20 and 32
// R15 - Three-wire handshake on every byte
// R16 - Service request and status byte in poll
// R17 - Secondary command bytes are ignored
// R18 - EOI marks the last byte
// R19 - Listen address is primary ORed 0x20
// R20 - Device clears return to defaults
`timescale 1ns/10ps
`default_nettype none
`include "gbd_defines.svh"

module gbd_decoder
  import gbd_pkg::*;
#(
  parameter int RESP_DEPTH = `GBD_RESP_DEPTH
)
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Bus pins sampled
  input  wire logic       atnIn,
  input  wire logic       ifcIn,
  input  wire logic       davIn,
  input  wire logic       nrfdIn,
  input  wire logic       ndacIn,
  input  wire logic       eoiIn,
  input  wire logic [7:0] dioIn,
  // Bus pins driven, enable low while driving
  output logic            nrfdOeN,
  output logic            ndacOeN,
  output logic            davOeN,
  output logic            eoiOeN,
  output logic            dioOeN,
  output logic [7:0]      dioOut,
  output logic            srqOeN,
  // Configuration
  input  wire logic       addrWr,
  input  wire logic [4:0] addrIn,
  output logic [4:0]      addrCur,
  output logic            addrRej,
  // Instrument side status
  input  wire logic       rsvSet,
  input  wire logic [7:0] statusIn,
  output logic            listening,
  output logic            talking,
  output logic            serialPoll,
  output logic            lockout,
  // Instrument side events
  output logic            trigPulse,
  output logic            clearPulse,
  output logic            gtlPulse,
  // Received data
  output logic [7:0]      dataOut,
  output logic            dataStb,
  output logic            dataEnd,
  // Response written at parse time
  input  wire logic       respWr,
  input  wire logic [7:0] respData,
  input  wire logic       respLast,
  output logic            respBusy,
  output logic            respRej,
  // Display text
  input  wire logic       dispWr,
  input  wire logic       dispLower,
  input  wire logic       dispClr,
  output logic [5:0]      upperLen,
  output logic [5:0]      lowerLen,
  output logic            dispRej
);

  initial
  begin
    if (RESP_DEPTH < 2 || RESP_DEPTH > (1 << `GBD_RESP_AW))
      $error("gbd_decoder: RESP_DEPTH out of range");
  end

  localparam logic [`GBD_RESP_AW:0] RESP_CAP =
    (`GBD_RESP_AW+1)'(RESP_DEPTH);

  gbd_state_s st_reg;
  gbd_state_s st_next;
  gbd_mem_if  memBus ();

  function automatic gbd_state_s bus_idle(input gbd_state_s s);
    gbd_state_s r;
    r        = s;
    r.listen = 1'b0;
    r.talk   = 1'b0;
    r.spoll  = 1'b0;
    r.src    = GBD_SRC_IDLE;
    r.davOeN = 1'b1;
    r.eoiOeN = 1'b1;
    r.dioOeN = 1'b1;
    return r;
  endfunction

  function automatic gbd_state_s defaults(input gbd_state_s s);
    gbd_state_s r;
    r          = s;
    r.respPend = 1'b0;
    r.respLen  = '0;
    r.rdPtr    = '0;
    r.srq      = 1'b0;
    r.upLen    = '0;
    r.loLen    = '0;
    return r;
  endfunction

  wire logic [7:0] myListen = `GBD_LISTEN_BASE | {3'h0, st_reg.addr};
  wire logic [7:0] myTalk   = `GBD_TALK_BASE | {3'h0, st_reg.addr};
  wire logic [7:0] cmd      = dioIn & `GBD_CMD_MASK;
  wire logic [7:0] stb      = {statusIn[7], st_reg.srq, statusIn[5:0]};
  wire logic       lastByte =
    (st_reg.rdPtr == `GBD_RESP_AW'(st_reg.respLen - 1'b1));
  // Acceptor takes part for every command and for data when listening
  wire logic       accOn    = atnIn || st_reg.listen;

  always_comb
  begin
    st_next          = st_reg;
    st_next.dataStb  = 1'b0;
    st_next.dataEnd  = 1'b0;
    st_next.trig     = 1'b0;
    st_next.devClr   = 1'b0;
    st_next.gtl      = 1'b0;
    st_next.addrRej  = 1'b0;
    st_next.respRej  = 1'b0;
    st_next.dispRej  = 1'b0;

    if (rsvSet)
      st_next.srq = 1'b1;                                   // [R16]

    // Acceptor handshake
    case (st_reg.acc)
      GBD_ACC_IDLE:
      begin
        st_next.nrfdOeN = 1'b1;
        st_next.ndacOeN = 1'b1;
        if (accOn && !davIn)
        begin
          st_next.ndacOeN = 1'b0;
          st_next.acc     = GBD_ACC_READY;
        end
      end
      GBD_ACC_READY:
      begin
        st_next.nrfdOeN = 1'b1;
        st_next.ndacOeN = 1'b0;
        if (!accOn)
        begin
          // Release both lines at once, no half-ready idle cycle
          st_next.ndacOeN = 1'b1;
          st_next.acc     = GBD_ACC_IDLE;
        end
        else if (davIn)
        begin
          st_next.nrfdOeN = 1'b0;                           // [R15]
          st_next.ndacOeN = 1'b1;                           // [R15]
          st_next.acc     = GBD_ACC_TAKEN;
          if (atnIn)                                        // [R07]
          begin
            if (cmd == `GBD_CMD_UNL)                        // [R06]
              st_next.listen = 1'b0;
            else if (cmd == `GBD_CMD_UNT)                   // [R06]
              st_next.talk = 1'b0;
            else if (cmd == myListen)                       // [R04] [R19]
              st_next.listen = 1'b1;
            else if (cmd == myTalk)                         // [R05]
              st_next.talk = 1'b1;
            else if (cmd[7:5] == `GBD_GRP_TALK)             // [R05]
              st_next.talk = 1'b0;
            else if (cmd == `GBD_CMD_LLO)                   // [R02]
              st_next.llo = 1'b1;
            else if (cmd == `GBD_CMD_DCL)                   // [R02]
            begin
              st_next        = defaults(st_next);           // [R20]
              st_next.devClr = 1'b1;
            end
            else if (cmd == `GBD_CMD_SPE)                   // [R03]
            begin
              st_next.spoll   = 1'b1;
              st_next.stbSent = 1'b0;
            end
            else if (cmd == `GBD_CMD_SPD)                   // [R03]
              st_next.spoll = 1'b0;
            else if (st_reg.listen && cmd == `GBD_CMD_GTL)  // [R01]
            begin
              st_next.gtl = 1'b1;
              st_next.llo = 1'b0;
            end
            else if (st_reg.listen && cmd == `GBD_CMD_SDC)  // [R01]
            begin
              st_next        = defaults(st_next);           // [R20]
              st_next.devClr = 1'b1;
            end
            else if (st_reg.listen && cmd == `GBD_CMD_GET)  // [R01]
              st_next.trig = 1'b1;
            // Secondary group and unknown codes fall through  [R17]
          end
          else
          begin
            st_next.dataByte = dioIn;                       // [R07]
            st_next.dataStb  = 1'b1;
            st_next.dataEnd  = eoiIn;                       // [R18]
          end
        end
      end
      GBD_ACC_TAKEN:
      begin
        // Hold not-ready until the source drops valid
        if (!davIn)
        begin
          st_next.nrfdOeN = 1'b1;
          st_next.ndacOeN = !accOn;
          st_next.acc     = accOn ? GBD_ACC_READY : GBD_ACC_IDLE;
        end
      end
      default:
        st_next.acc = GBD_ACC_IDLE;
    endcase

    // Source handshake, talker with ATN released
    case (st_reg.src)
      GBD_SRC_IDLE:
      begin
        st_next.davOeN = 1'b1;
        st_next.eoiOeN = 1'b1;
        st_next.dioOeN = 1'b1;
        if (st_reg.talk && !atnIn)
        begin
          if (st_reg.spoll && !st_reg.stbSent)
          begin
            st_next.dioOut = stb;                           // [R16]
            st_next.dioOeN = 1'b0;
            st_next.src    = GBD_SRC_SETUP;
          end
          else if (!st_reg.spoll && st_reg.respPend)
          begin
            st_next.dioOut = memBus.rdData;                 // [R12]
            st_next.dioOeN = 1'b0;
            st_next.eoiOeN = !lastByte;                     // [R18]
            st_next.src    = GBD_SRC_SETUP;
          end
        end
      end
      GBD_SRC_SETUP:
      begin
        if (atnIn || !st_reg.talk)
          st_next.src = GBD_SRC_IDLE;
        else if (!nrfdIn && ndacIn)                         // [R15]
        begin
          st_next.davOeN = 1'b0;
          st_next.src    = GBD_SRC_WAIT;
        end
      end
      GBD_SRC_WAIT:
      begin
        if (!ndacIn)                                        // [R15]
        begin
          st_next.davOeN = 1'b1;
          st_next.src    = GBD_SRC_IDLE;
          if (st_reg.spoll)
          begin
            st_next.stbSent = 1'b1;
            st_next.srq     = rsvSet;                       // [R16]
          end
          else if (lastByte)
          begin
            st_next.respPend = 1'b0;
            st_next.respLen  = '0;
            st_next.rdPtr    = '0;
          end
          else
            st_next.rdPtr = st_reg.rdPtr + 1'b1;
        end
        else if (atnIn)
          st_next.src = GBD_SRC_IDLE;
      end
      default:
        st_next.src = GBD_SRC_IDLE;
    endcase
    st_next.srqOeN = !st_next.srq;                          // [R16]

    // Response stored whole at parse time, one unit at a time
    if (respWr)
    begin
      if (st_reg.respPend || st_reg.respLen == RESP_CAP)    // [R13]
        st_next.respRej = 1'b1;
      else
      begin
        st_next.respLen  = st_reg.respLen + 1'b1;           // [R12]
        st_next.respPend = respLast;
      end
    end

    // Display text lengths
    if (dispClr)
    begin
      st_next.upLen = '0;
      st_next.loLen = '0;
    end
    else if (dispWr && !dispLower)
    begin
      if (st_reg.upLen == `GBD_UPPER_MAX)                   // [R14]
        st_next.dispRej = 1'b1;
      else
        st_next.upLen = st_reg.upLen + 1'b1;
    end
    else if (dispWr)
    begin
      if (st_reg.loLen == `GBD_LOWER_MAX)                   // [R14]
        st_next.dispRej = 1'b1;
      else
        st_next.loLen = st_reg.loLen + 1'b1;
    end

    // Address change and interface clear
    if (addrWr)
    begin
      if (addrIn > `GBD_ADDR_MAX)                           // [R10]
        st_next.addrRej = 1'b1;
      else
      begin
        st_next.addr = addrIn;                              // [R11]
        st_next      = bus_idle(st_next);                   // [R11]
      end
    end
    if (ifcIn)
      st_next = bus_idle(st_next);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      st_reg         <= '0;
      st_reg.addr    <= `GBD_ADDR_RESET;
      st_reg.acc     <= GBD_ACC_IDLE;
      st_reg.src     <= GBD_SRC_IDLE;
      st_reg.nrfdOeN <= 1'b1;
      st_reg.ndacOeN <= 1'b1;
      st_reg.davOeN  <= 1'b1;
      st_reg.eoiOeN  <= 1'b1;
      st_reg.dioOeN  <= 1'b1;
      st_reg.srqOeN  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Write lands at the current length; read uses the next pointer so
  // the registered byte is fresh when the source reloads
  assign memBus.wrEn   = respWr && !st_next.respRej;
  assign memBus.wrAddr = st_reg.respLen[`GBD_RESP_AW-1:0];
  assign memBus.wrData = respData;
  assign memBus.rdAddr = st_next.rdPtr;

  gbd_resp_mem #(
    .DEPTH (RESP_DEPTH)
  ) respMem (
    .mclk  (mclk),
    .port  (memBus.mem)
  );

  assign nrfdOeN    = st_reg.nrfdOeN;
  assign ndacOeN    = st_reg.ndacOeN;
  assign davOeN     = st_reg.davOeN;
  assign eoiOeN     = st_reg.eoiOeN;
  assign dioOeN     = st_reg.dioOeN;
  assign dioOut     = st_reg.dioOut;
  assign srqOeN     = st_reg.srqOeN;
  assign addrCur    = st_reg.addr;
  assign addrRej    = st_reg.addrRej;
  assign listening  = st_reg.listen;
  assign talking    = st_reg.talk;
  assign serialPoll = st_reg.spoll;
  assign lockout    = st_reg.llo;
  assign trigPulse  = st_reg.trig;
  assign clearPulse = st_reg.devClr;
  assign gtlPulse   = st_reg.gtl;
  assign dataOut    = st_reg.dataByte;
  assign dataStb    = st_reg.dataStb;
  assign dataEnd    = st_reg.dataEnd;
  assign respBusy   = st_reg.respPend;
  assign respRej    = st_reg.respRej;
  assign upperLen   = st_reg.upLen;
  assign lowerLen   = st_reg.loLen;
  assign dispRej    = st_reg.dispRej;

endmodule

`default_nettype wire

/* File: rtl/gbd_defines.svh */
// Constants of the bus command decoder: command codes, limits, resets.
// Included by the package and the design modules.
`ifndef GBD_DEFINES_SVH
`define GBD_DEFINES_SVH

`define GBD_CMD_GTL      8'h01
`define GBD_CMD_SDC      8'h04
`define GBD_CMD_GET      8'h08
`define GBD_CMD_LLO      8'h11
`define GBD_CMD_DCL      8'h14
`define GBD_CMD_SPE      8'h18
`define GBD_CMD_SPD      8'h19
`define GBD_CMD_UNL      8'h3f
`define GBD_CMD_UNT      8'h5f
`define GBD_GRP_LISTEN   3'h1
`define GBD_GRP_TALK     3'h2
`define GBD_LISTEN_BASE  8'h20
`define GBD_TALK_BASE    8'h40
`define GBD_CMD_MASK     8'h7f
`define GBD_ADDR_MAX     5'h1e
`define GBD_ADDR_RESET   5'h00
`define GBD_RQS_BIT      6
`define GBD_UPPER_MAX    6'h14
`define GBD_LOWER_MAX    6'h20
`define GBD_RESP_AW      6
`define GBD_RESP_DEPTH   64

`endif

/* File: rtl/gbd_mem_if.sv */
// Carrier between the decoder and its response memory.
// One write port, one registered read port, same clock.
`timescale 1ns/10ps
`default_nettype none
`include "gbd_defines.svh"

interface gbd_mem_if;
  logic                    wrEn;
  logic [`GBD_RESP_AW-1:0] wrAddr;
  logic [7:0]              wrData;
  logic [`GBD_RESP_AW-1:0] rdAddr;
  logic [7:0]              rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData,
                output rdAddr, input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData,
                input rdAddr, output rdData);
endinterface

`default_nettype wire

/* File: rtl/gbd_pkg.sv */
// Types of the bus command decoder.
// Assumes gbd_defines.svh for the widths.
`include "gbd_defines.svh"

package gbd_pkg;

  typedef enum logic [2:0] {
    GBD_ACC_IDLE  = 3'b001,
    GBD_ACC_READY = 3'b010,
    GBD_ACC_TAKEN = 3'b100
  } gbd_accept_e;

  typedef enum logic [2:0] {
    GBD_SRC_IDLE  = 3'b001,
    GBD_SRC_SETUP = 3'b010,
    GBD_SRC_WAIT  = 3'b100
  } gbd_source_e;

  typedef struct packed {
    logic [4:0]              addr;
    logic                    listen;
    logic                    talk;
    logic                    spoll;
    logic                    llo;
    logic                    srq;
    gbd_accept_e             acc;
    gbd_source_e             src;
    logic [`GBD_RESP_AW:0]   respLen;
    logic [`GBD_RESP_AW-1:0] rdPtr;
    logic                    respPend;
    logic                    stbSent;
    logic [5:0]              upLen;
    logic [5:0]              loLen;
    logic [7:0]              dataByte;
    logic                    dataStb;
    logic                    dataEnd;
    logic                    trig;
    logic                    devClr;
    logic                    gtl;
    logic                    addrRej;
    logic                    respRej;
    logic                    dispRej;
    logic                    nrfdOeN;
    logic                    ndacOeN;
    logic                    davOeN;
    logic                    eoiOeN;
    logic                    dioOeN;
    logic                    srqOeN;
    logic [7:0]              dioOut;
  } gbd_state_s;

endpackage

/* File: rtl/gbd_resp_mem.sv */
// Response byte store of the bus command decoder.
// Read data comes from a register one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
`include "gbd_defines.svh"

module gbd_resp_mem
  import gbd_pkg::*;
#(
  parameter int DEPTH = `GBD_RESP_DEPTH
)
(
  // Clock
  input  wire logic mclk,
  // Ports
  gbd_mem_if.mem    port
);

  initial
  begin
    if (DEPTH < 1 || DEPTH > (1 << `GBD_RESP_AW))
      $error("gbd_resp_mem: DEPTH out of range");
  end

  logic [7:0] store [DEPTH];
  logic [7:0] rdData_reg;

  always_ff @(posedge mclk)
  begin
    if (port.wrEn)
      store[port.wrAddr] <= port.wrData;
    rdData_reg <= store[port.rdAddr];
  end

  assign port.rdData = rdData_reg;

endmodule

`default_nettype wire

/* File: verif/gbd_ctrl_model.sv */
// Bus controller model: sends commands and data, reads talker bytes.
// Assumes the resolved line levels are fed back, 1 = asserted.
`timescale 1ns/10ps
`default_nettype none
module gbd_ctrl_model (
  // Clock
  input  wire logic       mclk,
  // Resolved lines
  input  wire logic       davIn,
  input  wire logic       nrfdIn,
  input  wire logic       ndacIn,
  input  wire logic       eoiIn,
  input  wire logic [7:0] dioIn,
  // Controller drive
  output logic            atn,
  output logic            dav,
  output logic            eoi,
  output logic            nrfd,
  output logic            ndac,
  output logic [7:0]      dio
);
  initial
  begin
    {atn, dav, eoi, nrfd, ndac} = 5'h00;
    dio = 8'h00;
  end
  // ATN set first and held for the whole group
  task automatic send(input logic a, input logic [7:0] b, input logic e,
                      output bit ok);
    int n;
    @(posedge mclk) atn <= a;
    repeat (2) @(posedge mclk);
    for (n = 0; n < 50 && !(ndacIn && !nrfdIn); n++) @(posedge mclk);
    ok = n < 50;
    if (ok)
    begin
      dio <= b;
      eoi <= e;
      @(posedge mclk) dav <= 1'b1;
      for (n = 0; n < 50 && !(nrfdIn && !ndacIn); n++) @(posedge mclk);
      ok = n < 50;
      dav <= 1'b0;
      eoi <= 1'b0;
      // Released data lines must not keep the old byte
      dio <= ~b;
    end
  endtask
  task automatic recv(output logic [7:0] b, output logic e);
    int n;
    @(posedge mclk)
    begin
      atn  <= 1'b0;
      ndac <= 1'b1;
    end
    for (n = 0; n < 50 && !davIn; n++) @(posedge mclk);
    b = dioIn;
    e = eoiIn;
    nrfd <= 1'b1;
    ndac <= 1'b0;
    for (n = 0; n < 50 && davIn; n++) @(posedge mclk);
    nrfd <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/gbd_decoder_assertions.sv */
// Checker for the bus command decoder, bound to gbd_decoder.
// Assumes one clock domain and the logical line levels at the ports.
`timescale 1ns/10ps
`default_nettype none
module gbd_decoder_assertions (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Bus
  input wire logic       atnIn,
  input wire logic       ifcIn,
  input wire logic       davIn,
  input wire logic       nrfdIn,
  input wire logic       ndacIn,
  input wire logic       eoiIn,
  input wire logic [7:0] dioIn,
  input wire logic       nrfdOeN,
  input wire logic       ndacOeN,
  input wire logic       davOeN,
  input wire logic       dioOeN,
  // Address and state
  input wire logic       addrWr,
  input wire logic [4:0] addrIn,
  input wire logic [4:0] addrCur,
  input wire logic       addrRej,
  input wire logic       listening,
  input wire logic       talking,
  input wire logic       serialPoll,
  // Events and data
  input wire logic       trigPulse,
  input wire logic       clearPulse,
  input wire logic [7:0] dataOut,
  input wire logic       dataStb,
  input wire logic       dataEnd,
  // Response store
  input wire logic       respWr,
  input wire logic       respBusy,
  input wire logic       respRej
);
  logic       take;
  logic       cmdT;
  logic [6:0] cmd;
  // Address writes reset the listener and talker state, so such edges are left out
  assign take = davIn && !ndacOeN && nrfdOeN && !ifcIn && !addrWr;
  assign cmdT = take && atnIn;
  assign cmd  = dioIn[6:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_addr_refused: assert property (
    addrWr && addrIn > 5'h1e |=> addrRej && $stable(addrCur))
    else $error("address above 30 accepted");
  a_addr_adopt: assert property (
    addrWr && addrIn <= 5'h1e |=> addrCur == $past(addrIn) && !listening
      && !talking && !serialPoll)
    else $error("address not adopted with bus reset");
  a_listen_own: assert property (
    cmdT && cmd == {2'b01, addrCur} |=> listening)
    else $error("own listen address missed");
  a_unlisten_wins: assert property (
    cmdT && cmd == 7'h3f |=> !listening)
    else $error("unlisten kept listener");
  a_talk_other: assert property (
    cmdT && cmd[6:5] == 2'b10 && cmd[4:0] != addrCur |=> !talking)
    else $error("talker kept after other talk");
  a_poll_mode: assert property (
    cmdT && cmd[6:1] == 6'h0c |=> serialPoll == !$past(dioIn[0]))
    else $error("serial poll mode wrong");
  a_trig_gated: assert property (
    cmdT && cmd == 7'h08 |=> trigPulse == $past(listening))
    else $error("trigger not gated by listener");
  a_clear_all: assert property (
    cmdT && cmd == 7'h14 |=> clearPulse)
    else $error("device clear missed");
  a_data_pass: assert property (
    take && !atnIn && listening |=> dataStb && dataOut == $past(dioIn)
      && dataEnd == $past(eoiIn))
    else $error("data byte not passed");
  a_second_ignored: assert property (
    cmdT && cmd[6:5] == 2'b11 |=> $stable(listening) && $stable(talking)
      && !trigPulse)
    else $error("secondary byte acted on");
  a_accept_answer: assert property (
    take |=> ndacOeN && !nrfdOeN)
    else $error("acceptor answer wrong");
  a_dav_after_ready: assert property (
    $fell(davOeN) |-> $past(!nrfdIn && ndacIn) && !dioOeN)
    else $error("valid before ready");
  a_one_unit: assert property (
    respWr && respBusy |=> respRej)
    else $error("second response unit taken");
  c_addressed: cover property (cmdT && cmd == 7'h04 && listening);
  c_data_end: cover property (take && !atnIn && eoiIn);
  c_source: cover property ($fell(davOeN));
endmodule

bind gbd_decoder gbd_decoder_assertions u_gbd_decoder_assertions (
  .mclk, .nrst, .atnIn, .ifcIn, .davIn, .nrfdIn, .ndacIn, .eoiIn, .dioIn,
  .nrfdOeN, .ndacOeN, .davOeN, .dioOeN, .addrWr, .addrIn, .addrCur,
  .addrRej, .listening, .talking, .serialPoll, .trigPulse, .clearPulse,
  .dataOut, .dataStb, .dataEnd, .respWr, .respBusy, .respRej);
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench of the bus command decoder.
// Assumes gbd_decoder, the controller model and the checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module testbench;
  logic       mclk, nrst, addrWr, rsvSet, respWr, respLast, dispWr;
  logic       dispLower, dispClr, atnIn, cDav, cEoi, cNrfd, cNdac;
  logic       nrfdOeN, ndacOeN, davOeN, eoiOeN, dioOeN, srqOeN, addrRej;
  logic       listening, talking, serialPoll, lockout, trigPulse;
  logic       clearPulse, gtlPulse, dataStb, dataEnd, respBusy, respRej;
  logic       dispRej, e;
  logic [4:0] addrIn, addrCur;
  logic [7:0] statusIn, respData, dioOut, dataOut, cDio, b;
  logic [5:0] upperLen, lowerLen;
  logic [8:0] rx[$];
  int         fails, total_checks, nTrig, nClr, nGtl;
  bit         ok;
  // Open-drain control lines: asserted if any party pulls; data lines take dioOut while dioOeN is low
  wire logic       davIn  = cDav | ~davOeN;
  wire logic       nrfdIn = cNrfd | ~nrfdOeN;
  wire logic       ndacIn = cNdac | ~ndacOeN;
  wire logic       eoiIn  = cEoi | ~eoiOeN;
  wire logic [7:0] dioIn  = dioOeN ? cDio : dioOut;

  gbd_decoder u_gbd_decoder (.mclk, .nrst, .atnIn, .ifcIn(1'b0), .davIn,
    .nrfdIn, .ndacIn, .eoiIn, .dioIn, .nrfdOeN, .ndacOeN, .davOeN, .eoiOeN,
    .dioOeN, .dioOut, .srqOeN, .addrWr, .addrIn, .addrCur, .addrRej,
    .rsvSet, .statusIn, .listening, .talking, .serialPoll, .lockout,
    .trigPulse, .clearPulse, .gtlPulse, .dataOut, .dataStb, .dataEnd,
    .respWr, .respData, .respLast, .respBusy, .respRej, .dispWr,
    .dispLower, .dispClr, .upperLen, .lowerLen, .dispRej);
  gbd_ctrl_model u_gbd_ctrl_model (.mclk, .davIn, .nrfdIn, .ndacIn, .eoiIn,
    .dioIn, .atn(atnIn), .dav(cDav), .eoi(cEoi), .nrfd(cNrfd),
    .ndac(cNdac), .dio(cDio));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (trigPulse === 1'b1)
      nTrig++;
    if (clearPulse === 1'b1)
      nClr++;
    if (gtlPulse === 1'b1)
      nGtl++;
    if (dataStb === 1'b1)
      rx.push_back({dataEnd, dataOut});
  end
  task automatic cmd(input logic [7:0] c);
    u_gbd_ctrl_model.send(1'b1, c, 1'b0, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic addrWrite(input logic [4:0] a);
    @(posedge mclk)
    begin
      addrWr <= 1'b1;
      addrIn <= a;
    end
    @(posedge mclk) addrWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic t_address;
    addrWrite(5'h1f);
    `CHK(addrRej, 1'b1)
    `CHK(addrCur, 5'h00)
    addrWrite(5'h1b);
    cmd(8'h3b);
    `CHK(listening, 1'b1)
    addrWrite(5'h1e);
    `CHK({addrCur, listening}, 6'h3c)
    addrWrite(5'h1b);
  endtask
  task automatic t_cmds;
    logic [7:0] acg[3] = '{8'h01, 8'h04, 8'h08};
    int         base;
    base = nGtl + nClr + nTrig;
    cmd(8'h3f);
    foreach (acg[i]) cmd(acg[i]);
    `CHK(nGtl + nClr + nTrig, base)
    cmd(8'h3f);
    cmd(8'h3b);
    foreach (acg[i]) cmd(acg[i]);
    // Let the pulse counters see the last pulse
    @(posedge mclk);
    `CHK(nGtl + nClr + nTrig, base + 3)
    cmd(8'h3f);
    cmd(8'h14);
    @(posedge mclk);
    `CHK(nClr, 2)
    cmd(8'h11);
    `CHK(lockout, 1'b1)
  endtask
  task automatic t_data;
    logic [7:0] txt[4] = '{8'h2a, 8'h52, 8'h53, 8'h54};
    cmd(8'h3f);
    cmd(8'h3b);
    cmd(8'h7b);
    `CHK({listening, talking}, 2'b10)
    rx.delete();
    foreach (txt[i]) u_gbd_ctrl_model.send(1'b0, txt[i], i == 3, ok);
    @(posedge mclk);
    `CHK(rx.size(), 4)
    foreach (txt[i]) `CHK(rx[i], {i == 3, txt[i]})
    cmd(8'h3f);
    u_gbd_ctrl_model.send(1'b0, 8'h41, 1'b0, ok);
    `CHK({ok, rx.size()}, {1'b0, 32'd4})
  endtask
  task automatic t_poll;
    @(posedge mclk)
    begin
      rsvSet   <= 1'b1;
      statusIn <= 8'h05;
    end
    @(posedge mclk) rsvSet <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(srqOeN, 1'b0)
    cmd(8'h5b);
    cmd(8'h18);
    `CHK({talking, serialPoll}, 2'b11)
    u_gbd_ctrl_model.recv(b, e);
    `CHK(b, 8'h45)
    cmd(8'h19);
    `CHK({serialPoll, srqOeN}, 2'b01)
    cmd(8'h45);
    `CHK(talking, 1'b0)
    cmd(8'h5b);
    cmd(8'h5f);
    `CHK(talking, 1'b0)
  endtask
  task automatic t_resp;
    logic [7:0] rsp[4] = '{8'h31, 8'h32, 8'h0a, 8'h39};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      respWr   <= 1'b1;
      respData <= rsp[i];
      respLast <= i == 2;
    end
    @(posedge mclk)
    begin
      respWr   <= 1'b0;
      respLast <= 1'b0;
    end
    @(posedge mclk);
    `CHK({respRej, respBusy}, 2'b11)
    cmd(8'h5b);
    for (int i = 0; i < 3; i++)
    begin
      u_gbd_ctrl_model.recv(b, e);
      `CHK({e, b}, {i == 2, rsp[i]})
    end
    repeat (3) @(posedge mclk);
    `CHK(respBusy, 1'b0)
    cmd(8'h5f);
  endtask
  task automatic t_disp;
    for (int l = 0; l < 2; l++)
    begin
      @(posedge mclk)
      begin
        dispLower <= l[0];
        dispWr    <= 1'b1;
      end
      // One write past the limit
      repeat (l ? 33 : 21) @(posedge mclk);
      dispWr <= 1'b0;
      @(posedge mclk);
      `CHK(dispRej, 1'b1)
      `CHK(l ? lowerLen : upperLen, l ? 6'h20 : 6'h14)
    end
    @(posedge mclk) dispClr <= 1'b1;
    @(posedge mclk) dispClr <= 1'b0;
    @(posedge mclk);
    `CHK({upperLen, lowerLen}, 12'h000)
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {nrst, addrWr, rsvSet, respWr, respLast, dispWr, dispLower} = 7'h00;
    {dispClr, addrIn, statusIn, respData} = 22'h000000;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    `CHK({ndacOeN, nrfdOeN, davOeN, addrCur}, 8'he0)
    t_address;
    t_cmds;
    t_data;
    t_poll;
    t_resp;
    t_disp;
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
